// File: core/dtc_timer_counter.sv
/*
  Two 16-bit timer/counters with mode control, overflow flags and a
  masked interrupt. Assumes a synchronous register port and pins that
  are already synchronous to clk_in.
*/
`timescale 1ns/1ps
`include "dtc_params.svh"

// What this block does
// - Gate select zero: only the run bit enables counting.
// - Gate select one with run set: count only while gate input high.
// - Source select zero: count ticks of the divided system clock.
// - Source select one: count each falling edge on the count pin.
// - Mode 0: high byte counts, low five bits act as prescaler.
// - Mode 1: high and low bytes form one 16-bit counter.
// - Mode 2: low byte counts, reloads from high byte on overflow.
// - Mode 3: either timer halts and keeps its count.
// - Mode register and all four count bytes reset to zero.
// - Count bytes chain or split as the selected mode requires.
// - Overflow sets the timer's flag; interrupt acknowledge clears it.
module dtc_timer_counter
#(
  parameter int TICK_CYC = `DTC_TICK_CYC
)
(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire dtc_pkg::dtc_bus_req_t bus_in,
  input  wire dtc_pkg::dtc_pins_t    t0_pins_in,
  input  wire dtc_pkg::dtc_pins_t    t1_pins_in,
  output logic [7:0]             rdata_out,
  output logic                   irq_out
);
  import dtc_pkg::*;

  if (TICK_CYC < 1 || TICK_CYC > 65535)
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0]  timer_mode_control_r;
  logic [7:0]  count_low_r [2];
  logic [7:0]  count_high_r [2];
  logic [1:0]  run_r;
  logic [1:0]  flag_r;
  logic [1:0]  mask_r;
  logic [15:0] tick_cnt_r;
  logic        tick_r;
  logic [1:0]  pin_prev_r;
  logic [1:0]  pin_edge;
  logic [1:0]  count_en;
  logic [1:0]  ovf;
  logic [7:0]  low_nxt [2];
  logic [7:0]  high_nxt [2];
  dtc_tcfg_t   cfg [2];
  dtc_pins_t   pins [2];
  dtc_bus_st_t bus_st_r;

  wire wr = bus_in.wr;
  wire rd = bus_in.rd;

  assign pins[0] = t0_pins_in;
  assign pins[1] = t1_pins_in;
  assign cfg[0] = dtc_tcfg_t'(timer_mode_control_r[3:0]);
  assign cfg[1] = dtc_tcfg_t'(timer_mode_control_r[7:4]);

  // --------------------------------------------------------------------
  // Divided system clock
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == 16'(TICK_CYC - 1))
    begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Count pin edge detect
  // --------------------------------------------------------------------
  // Pins are already synchronous, so one stored sample suffices
  // Reset value low: a pin already low at release is not an edge
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_prev_r <= 2'h0;
    else
      pin_prev_r <= {pins[1].count_pin, pins[0].count_pin};
  end

  // --------------------------------------------------------------------
  // Per-timer count logic
  // --------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    always_comb
    begin
      pin_edge[i] = pin_prev_r[i] & ~pins[i].count_pin;
      count_en[i] = run_r[i]
                  & (~cfg[i].gate_select | pins[i].gate_input)
                  & (cfg[i].source_select ? pin_edge[i]
                                          : tick_r);
      low_nxt[i]  = count_low_r[i];
      high_nxt[i] = count_high_r[i];
      ovf[i]      = 1'b0;
      if (count_en[i])
      begin
        case (cfg[i].mode)
          DTC_MODE_PRESCALE:
          begin
            low_nxt[i] = {count_low_r[i][7:5], count_low_r[i][4:0] + 5'h01};
            if (count_low_r[i][4:0] == 5'h1F)
            begin
              high_nxt[i] = count_high_r[i] + 8'h01;
              ovf[i]      = (count_high_r[i] == 8'hFF);
            end
          end
          DTC_MODE_WIDE:
          begin
            {high_nxt[i], low_nxt[i]} =
              {count_high_r[i], count_low_r[i]} + 16'h0001;
            ovf[i] = ({count_high_r[i], count_low_r[i]} == 16'hFFFF);
          end
          DTC_MODE_RELOAD:
          begin
            ovf[i]     = (count_low_r[i] == 8'hFF);
            low_nxt[i] = ovf[i] ? count_high_r[i]
                                : count_low_r[i] + 8'h01;
          end
          DTC_MODE_HALT: ;
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Register port writes and count updates
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      timer_mode_control_r <= `DTC_RST_BYTE;
      count_low_r[0]       <= `DTC_RST_BYTE;
      count_low_r[1]       <= `DTC_RST_BYTE;
      count_high_r[0]      <= `DTC_RST_BYTE;
      count_high_r[1]      <= `DTC_RST_BYTE;
      run_r                <= 2'h0;
      mask_r               <= 2'h0;
    end
    else
    begin
      count_low_r  <= low_nxt;
      count_high_r <= high_nxt;
      // A software write overrides a same-cycle count step
      if (wr)
      begin
        case (bus_in.addr)
          `DTC_OFS_MODE:     timer_mode_control_r <= bus_in.wdata;
          `DTC_OFS_T0_LOW:   count_low_r[0]  <= bus_in.wdata;
          `DTC_OFS_T1_LOW:   count_low_r[1]  <= bus_in.wdata;
          `DTC_OFS_T0_HIGH:  count_high_r[0] <= bus_in.wdata;
          `DTC_OFS_T1_HIGH:  count_high_r[1] <= bus_in.wdata;
          `DTC_OFS_CONTROL:
            run_r <= {bus_in.wdata[`DTC_CTL_T1_RUN],
                      bus_in.wdata[`DTC_CTL_T0_RUN]};
          `DTC_OFS_IRQ_MASK: mask_r <= bus_in.wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Overflow flags
  // --------------------------------------------------------------------
  // Acknowledge stands for the vector fetch; a new overflow wins over it
  logic [1:0] ack;
  always_comb
  begin
    ack = 2'h0;
    if (wr && bus_in.addr == `DTC_OFS_CONTROL)
      ack = {bus_in.wdata[`DTC_CTL_T1_ACK], bus_in.wdata[`DTC_CTL_T0_ACK]};
    else if (wr && bus_in.addr == `DTC_OFS_IRQ_STAT)
      ack = bus_in.wdata[1:0];
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      flag_r <= 2'h0;
    else
      flag_r <= (flag_r & ~ack) | ovf;
  end

  assign irq_out = |(flag_r & mask_r);

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_out <= 8'h00;
      bus_st_r  <= DTC_ST_IDLE;
    end
    else
    begin
      bus_st_r  <= rd ? DTC_ST_READ : (wr ? DTC_ST_WRITE : DTC_ST_IDLE);
      rdata_out <= 8'h00;
      if (rd)
      begin
        case (bus_in.addr)
          `DTC_OFS_MODE:     rdata_out <= timer_mode_control_r;
          `DTC_OFS_T0_LOW:   rdata_out <= count_low_r[0];
          `DTC_OFS_T1_LOW:   rdata_out <= count_low_r[1];
          `DTC_OFS_T0_HIGH:  rdata_out <= count_high_r[0];
          `DTC_OFS_T1_HIGH:  rdata_out <= count_high_r[1];
          `DTC_OFS_CONTROL:
            rdata_out <= {2'h0, flag_r, 2'h0, run_r};
          `DTC_OFS_IRQ_STAT: rdata_out <= {6'h00, flag_r};
          `DTC_OFS_IRQ_MASK: rdata_out <= {6'h00, mask_r};
          default:           rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  gate_blocks_a: assert property (
    cfg[0].gate_select && !pins[0].gate_input |-> !count_en[0])
    else $error("timer zero counted with gate low");
  run_blocks_a: assert property (
    !run_r[1] && !wr |=> $stable(count_low_r[1]) && $stable(count_high_r[1]))
    else $error("timer one moved while stopped");
  halt_keeps_a: assert property (
    cfg[1].mode == DTC_MODE_HALT && !wr |=> $stable(count_low_r[1]))
    else $error("timer one moved in halt mode");
  reload_value_a: assert property (
    cfg[0].mode == DTC_MODE_RELOAD && ovf[0] && !wr
    |=> count_low_r[0] == $past(count_high_r[0]))
    else $error("reload took wrong value");
  flag_sets_a: assert property (
    ovf[1] |=> flag_r[1]) else $error("overflow flag not set");
  wide_carry_a: assert property (
    cfg[0].mode == DTC_MODE_WIDE && count_en[0] && !wr
    && count_low_r[0] == 8'hFF
    |=> count_high_r[0] == $past(count_high_r[0]) + 8'h01)
    else $error("16-bit carry lost");
  edge_count_a: assert property (
    cfg[1].source_select && run_r[1] && !cfg[1].gate_select
    && $fell(pins[1].count_pin) |-> count_en[1])
    else $error("falling edge not counted");
  tick_period_a: assert property (
    tick_r && TICK_CYC > 1 |=> !tick_r)
    else $error("tick longer than one cycle");
  irq_level_a: assert property (
    wr && bus_in.addr == `DTC_OFS_IRQ_MASK
    && (bus_in.wdata[1:0] & flag_r) != 2'h0 |=> irq_out)
    else $error("interrupt not raised");
  prescale_step_a: assert property (
    cfg[0].mode == DTC_MODE_PRESCALE && count_en[0] && !wr
    && count_low_r[0][4:0] == 5'h1F
    |=> count_low_r[0][4:0] == 5'h00
        && count_high_r[0] == $past(count_high_r[0]) + 8'h01)
    else $error("prescaler wrap lost");
  flag_clear_a: assert property (
    wr && bus_in.addr == `DTC_OFS_IRQ_STAT && bus_in.wdata[0] && !ovf[0]
    |=> !flag_r[0])
    else $error("flag not cleared by a one");
  rd_window_a: assert property (
    bus_st_r != DTC_ST_READ |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");

  c_ovf0_c: cover property (ovf[0] ##1 irq_out);
  c_reload_c: cover property (cfg[0].mode == DTC_MODE_RELOAD && ovf[0]);
  c_edge_c: cover property (cfg[0].source_select && count_en[0]);
  c_gate_c: cover property (cfg[1].gate_select && count_en[1]);
endmodule

// File: core/dtc_params.svh
/*
  Offsets, field positions, reset values and timing counts of the dual
  timer/counter. Assumes inclusion by bare name from the design files.
*/
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTC_OFS_MODE      8'h89
`define DTC_OFS_T0_LOW    8'h8A
`define DTC_OFS_T1_LOW    8'h8B
`define DTC_OFS_T0_HIGH   8'h8C
`define DTC_OFS_T1_HIGH   8'h8D
`define DTC_OFS_CONTROL   8'h90
`define DTC_OFS_IRQ_STAT  8'h91
`define DTC_OFS_IRQ_MASK  8'h92

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DTC_CTL_T0_RUN    0
`define DTC_CTL_T1_RUN    1
`define DTC_CTL_T0_ACK    2
`define DTC_CTL_T1_ACK    3
`define DTC_CTL_T0_FLAG   4
`define DTC_CTL_T1_FLAG   5

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DTC_RST_BYTE      8'h00
`define DTC_CLK_HZ        50000000
`define DTC_TICK_NS       240
`define DTC_TICK_CYC      ((`DTC_TICK_NS * (`DTC_CLK_HZ / 1000000)) / 1000)

`endif

// File: core/dtc_pkg.sv
/*
  Types shared by the dual timer/counter.
  Assumes no surroundings beyond a SystemVerilog compiler.
*/
package dtc_pkg;

  typedef enum logic [1:0]
  {
    DTC_MODE_PRESCALE = 2'h0,
    DTC_MODE_WIDE     = 2'h1,
    DTC_MODE_RELOAD   = 2'h2,
    DTC_MODE_HALT     = 2'h3
  } dtc_mode_t;

  typedef struct packed
  {
    logic      gate_select;
    logic      source_select;
    dtc_mode_t mode;
  } dtc_tcfg_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_bus_req_t;

  typedef struct packed
  {
    logic count_pin;
    logic gate_input;
  } dtc_pins_t;

  typedef enum logic [2:0]
  {
    DTC_ST_IDLE  = 3'b001,
    DTC_ST_READ  = 3'b010,
    DTC_ST_WRITE = 3'b100
  } dtc_bus_st_t;

endpackage

// File: verification/dtc_pin_model.sv
/*
  Far-side model of one timer's count pin and gate input.
  Assumes it runs on the same clock as the timer block.
*/
`timescale 1ns/1ps

module dtc_pin_model
(
  input  wire logic          clk_in,
  output dtc_pkg::dtc_pins_t pins_out
);
  import dtc_pkg::*;

  // Count pin idles high, gate starts low
  initial pins_out = 2'h2;

  // Each pulse is one falling edge, held for several clocks so that the
  // block's sampler cannot miss it
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk_in) pins_out.count_pin <= 1'b0;
      repeat (3) @(posedge clk_in) pins_out.count_pin <= 1'b1;
    end
    repeat (4) @(posedge clk_in);
  endtask

  task automatic set_gate(input logic g);
    @(posedge clk_in);
    pins_out.gate_input <= g;
  endtask
endmodule

// File: verification/testbench.sv
/*
  Self-checking bench of the dual timer/counter.
  Assumes the core files and the pin model are compiled first.
*/
`timescale 1ns/1ps

module testbench;
  import dtc_pkg::*;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } dtc_row_t;

  logic         clk_in;
  logic         reset_n_in;
  dtc_bus_req_t bus_in;
  dtc_pins_t    t0_pins;
  dtc_pins_t    t1_pins;
  logic [7:0]   rdata_out;
  logic         irq_out;
  int           num_errors;
  int           cmp_count;
  dtc_row_t     rows [8] = '{'{8'h89, 8'hA5, 8'hA5}, '{8'h8A, 8'h12, 8'h12},
    '{8'h8B, 8'h34, 8'h34}, '{8'h8C, 8'h56, 8'h56}, '{8'h8D, 8'h78, 8'h78},
    '{8'h92, 8'h03, 8'h03}, '{8'h80, 8'hFF, 8'h00}, '{8'h60, 8'hFF, 8'h00}};

  dtc_timer_counter #(.TICK_CYC(2)) u_dtc_timer_counter
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .bus_in     (bus_in),
    .t0_pins_in (t0_pins),
    .t1_pins_in (t1_pins),
    .rdata_out  (rdata_out),
    .irq_out    (irq_out)
  );

  dtc_pin_model u_dtc_pin_model_t0 (.clk_in(clk_in), .pins_out(t0_pins));
  dtc_pin_model u_dtc_pin_model_t1 (.clk_in(clk_in), .pins_out(t1_pins));

  // ----------------------------------------------------------------------
  // Clock, bus tasks and compares
  // ----------------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rd(input string n, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(n, e, d);
  endtask

  task automatic chk1(input string n, input logic e);
    chk8(n, {7'h00, e}, {7'h00, irq_out});
  endtask

  task automatic setup(input logic [7:0] m, input logic [7:0] lo,
                       input logic [7:0] hi);
    wr(8'h89, m);
    wr(8'h8A, lo);
    wr(8'h8C, hi);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    reset_n_in = 1'b0;
    bus_in = '0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 5; i++)
      chk_rd("reset value", 8'h89 + 8'(i), 8'h00);
    chk1("irq after reset", 1'b0);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      chk_rd("register", rows[i].addr, rows[i].exp);
    end
    $display("test registers done");
    // 16-bit count through FFFF, flag and interrupt
    wr(8'h92, 8'h00);
    setup(8'h05, 8'hFE, 8'hFF);
    wr(8'h90, 8'h01);
    u_dtc_pin_model_t0.pulses(3);
    chk_rd("wide low", 8'h8A, 8'h01);
    chk_rd("wide high", 8'h8C, 8'h00);
    chk_rd("flag", 8'h91, 8'h01);
    chk1("irq masked", 1'b0);
    wr(8'h92, 8'h01);
    chk1("irq unmasked", 1'b1);
    wr(8'h91, 8'h01);
    chk1("irq cleared", 1'b0);
    $display("test wide done");
    setup(8'h06, 8'hFE, 8'hF0);
    u_dtc_pin_model_t0.pulses(3);
    chk_rd("reload low", 8'h8A, 8'hF1);
    chk_rd("reload high", 8'h8C, 8'hF0);
    chk_rd("reload flag", 8'h91, 8'h01);
    wr(8'h91, 8'h01);
    $display("test reload done");
    // Prescaler wraps in the low five bits, upper bits kept
    setup(8'h04, 8'hFF, 8'h00);
    u_dtc_pin_model_t0.pulses(1);
    chk_rd("prescale low", 8'h8A, 8'hE0);
    chk_rd("prescale high", 8'h8C, 8'h01);
    $display("test prescale done");
    setup(8'h0D, 8'h00, 8'h00);
    u_dtc_pin_model_t0.pulses(2);
    chk_rd("gate low", 8'h8A, 8'h00);
    u_dtc_pin_model_t0.set_gate(1'b1);
    u_dtc_pin_model_t0.pulses(2);
    chk_rd("gate high", 8'h8A, 8'h02);
    u_dtc_pin_model_t0.set_gate(1'b0);
    $display("test gate done");
    wr(8'h90, 8'h00);
    setup(8'h05, 8'h00, 8'h00);
    u_dtc_pin_model_t0.pulses(2);
    chk_rd("run off", 8'h8A, 8'h00);
    wr(8'h90, 8'h01);
    u_dtc_pin_model_t0.pulses(1);
    chk_rd("run on", 8'h8A, 8'h01);
    $display("test run done");
    wr(8'h89, 8'h70);
    wr(8'h8B, 8'h33);
    wr(8'h90, 8'h02);
    u_dtc_pin_model_t1.pulses(2);
    chk_rd("halt", 8'h8B, 8'h33);
    wr(8'h89, 8'h50);
    u_dtc_pin_model_t1.pulses(2);
    chk_rd("timer one wide", 8'h8B, 8'h35);
    wr(8'h89, 8'hD0);
    u_dtc_pin_model_t1.pulses(1);
    chk_rd("t1 gate low", 8'h8B, 8'h35);
    u_dtc_pin_model_t1.set_gate(1'b1);
    u_dtc_pin_model_t1.pulses(1);
    chk_rd("t1 gate high", 8'h8B, 8'h36);
    u_dtc_pin_model_t1.set_gate(1'b0);
    $display("test halt done");
    // Timer source: the divided clock must move the count
    setup(8'h01, 8'h00, 8'h00);
    wr(8'h90, 8'h01);
    repeat (20) @(posedge clk_in);
    wr(8'h90, 8'h00);
    // Run stands for 22 edges, one tick every second clock
    chk_rd("timer source", 8'h8A, 8'h0B);
    $display("test timer source done");
    // Reset in mid-run puts every register back to zero
    wr(8'h8D, 8'h5A);
    wr(8'h90, 8'h03);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 5; i++)
      chk_rd("mid-run reset", 8'h89 + 8'(i), 8'h00);
    chk_rd("run after reset", 8'h90, 8'h00);
    chk1("irq after mid-run reset", 1'b0);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule
